//--- inc/riec_map.svh
`ifndef RIEC_MAP_SVH
`define RIEC_MAP_SVH
// register indices (printed offsets are not multiples of four: byte address = 4 * index)
`define RIEC_IDX_EDGE_SEL   16'hfff2
`define RIEC_IDX_EN_FIRST   16'hfff3
`define RIEC_IDX_EN_SECOND  16'hfff4
`define RIEC_IDX_REQ_FIRST  16'hfff6
`define RIEC_IDX_REQ_SECOND 16'hfff7
`define RIEC_IDX_WKP_REQ    16'hfff9
`define RIEC_IDX_CTRL       16'hfffa
// reset values
`define RIEC_RST_EDGE_SEL   8'he0
`define RIEC_RST_EN_FIRST   8'h00
`define RIEC_RST_EN_SECOND  8'h00
`define RIEC_RST_REQ_FIRST  8'h20
`define RIEC_RST_REQ_SECOND 8'h00
`define RIEC_RST_WKP_REQ    8'h00
`define RIEC_EDGE_RSVD      8'he0
// vector numbers and addresses
`define RIEC_VEC_RESET      5'd0
`define RIEC_VEC_IRQ0       5'd4
`define RIEC_VEC_WKP        5'd9
`define RIEC_VEC_SER1       5'd10
`define RIEC_VEC_TMR_A      5'd11
`define RIEC_VEC_TMR_B      5'd12
`define RIEC_VEC_TMR_C      5'd13
`define RIEC_VEC_TMR_FL     5'd14
`define RIEC_VEC_TMR_FH     5'd15
`define RIEC_VEC_TMR_G      5'd16
`define RIEC_VEC_SER2       5'd17
`define RIEC_VEC_SER3       5'd18
`define RIEC_VEC_ADC        5'd19
`define RIEC_VEC_DIRECT     5'd20
`define RIEC_RESET_VEC_ADDR 16'h0000
// timing
`define RIEC_BOOT_WAIT_CYC  8192
`endif

//--- inc/riec_pkg.sv
package riec_pkg;
  // reset sequencer, gray along the usual path
  typedef enum logic [1:0] {
    RIEC_HOLD = 2'b00,
    RIEC_WAIT = 2'b01,
    RIEC_VECT = 2'b11,
    RIEC_RUN  = 2'b10
  } riec_seq_t;

  // internal peripheral events
  typedef struct packed {
    logic       ser1_done;
    logic       tmr_a_ovf;
    logic       tmr_b_ovf;
    logic       tmr_c_ovf;
    logic       tmr_c_unf;
    logic [1:0] tmr_fl;     // compare, overflow
    logic [1:0] tmr_fh;     // compare, overflow
    logic [1:0] tmr_g;      // capture, overflow
    logic [1:0] ser2;       // done, aborted
    logic [5:0] ser3;       // six events
    logic       adc_done;
    logic       direct_xfer;
  } riec_evt_t;

  // cpu-facing request
  typedef struct packed {
    logic        req;
    logic [4:0]  vec_num;
    logic [15:0] vec_addr;
  } riec_cpu_req_t;

  // full block state
  typedef struct packed {
    riec_seq_t   seq;
    logic [13:0] wait_cnt;
    logic        boot_prev;
    logic        boot_rose;
    logic        gmask;
    logic        first_instr;
    logic [4:0]  edge_sel;
    logic [4:0]  irq_prev;
    logic [7:0]  en_first;
    logic [7:0]  en_second;
    logic [7:0]  req_first;
    logic [7:0]  req_second;
    logic [7:0]  wkp_req;
    logic [31:0] prdata;
  } riec_state_t;
endpackage

//--- rtl/riec_ctrl.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "riec_map.svh"
// Behaviour
// - reset outranks all, loads every register's reset value
// - reset exception starts right after release with boot pin high
// - interrupts taken only at instruction boundary
// - reset pin low halts everything immediately
// - boot pin high: start on release
// - boot pin low: wait rise, 8192 cycles
// - reset exception sets global mask
// - program counter loaded from vector zero
// - first instruction runs before any interrupt
// - thirteen external, twenty internal sources
// - highest fixed priority serviced first
// - mask set: flags still set, none accepted
// - each edge pin rising or falling
// - edge pins vectors 4-8, wakeups 9
// - counter c over/underflow share vector 13
// - counter f halves vectors 14 and 15
// - counter g events share vector 16
// - six third-serial events share vector 18
// - vector addresses 2 to 7 unused
// - request flags cleared by writing zero
module riec_ctrl
  import riec_pkg::*;
#(
  parameter int BOOT_WAIT_CYC = `RIEC_BOOT_WAIT_CYC  // delay after boot pin rises
) (
  input  wire logic          pclk,             // system clock, 50 MHz
  input  wire logic          presetn,          // system init pin, active low
  input  wire logic [15:0]   paddr,            // apb byte address
  input  wire logic          psel,             // apb select
  input  wire logic          penable,          // apb access phase
  input  wire logic          pwrite,           // apb direction
  input  wire logic [31:0]   pwdata,           // apb write data
  output logic      [31:0]   prdata,           // apb read data
  output logic               pready,           // apb ready
  output logic               pslverr,          // apb error, unmapped address
  input  wire logic          boot_select_pin,  // mode strap
  input  wire logic [4:0]    irq_pins,         // edge-sensed pins
  input  wire logic [7:0]    wakeup_pins,      // wakeup request pulses
  input  wire riec_evt_t     periph_evt,       // internal event pulses
  input  wire logic          instr_boundary,   // cpu finished instr or exception
  input  wire logic          cpu_ack,          // cpu took the vector
  input  wire logic          rte_clear_mask,   // cpu clears global mask
  input  wire logic          rte_set_mask,     // cpu sets global mask
  output logic               cpu_in_reset,     // cpu and peripherals held
  output logic               cpu_gmask,        // global mask bit of cond code reg
  output riec_cpu_req_t      cpu_req           // vector request to cpu
);

  riec_state_t st_reg;   // all state
  riec_state_t st_next;  // next state

  logic        wr_stb;     // write commits this cycle
  logic        rd_stb;     // read commits this cycle
  logic [13:0] idx;        // word index of the access
  logic        hit;        // access maps to a register
  logic [4:0]  irq_edge;   // detected edges on irq pins
  logic [7:0]  wr_byte;    // low byte of write data
  logic [19:0] pend;       // enabled pending, priority order

  assign idx     = paddr[15:2];
  assign wr_stb  = psel & penable & pwrite;
  assign rd_stb  = psel & ~penable & ~pwrite;  // captured in setup, stands through access
  assign wr_byte = pwdata[7:0];
  assign pready  = 1'b1;  // zero wait states
  assign prdata  = st_reg.prdata;
  assign pslverr = psel & penable & ~hit;

  // address decode, indices kept 14 bits wide
  always_comb begin
    if (idx == 14'(`RIEC_IDX_EDGE_SEL)) begin
      hit = 1'b1;
    end else if (idx == 14'(`RIEC_IDX_EN_FIRST) || idx == 14'(`RIEC_IDX_EN_SECOND)) begin
      hit = 1'b1;
    end else if (idx == 14'(`RIEC_IDX_REQ_FIRST) || idx == 14'(`RIEC_IDX_REQ_SECOND)) begin
      hit = 1'b1;
    end else if (idx == 14'(`RIEC_IDX_WKP_REQ) || idx == 14'(`RIEC_IDX_CTRL)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // edge detection per pin, polarity per bit
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_edge
      assign irq_edge[g] = st_reg.edge_sel[g] ? (irq_pins[g] & ~st_reg.irq_prev[g])
                                              : (~irq_pins[g] & st_reg.irq_prev[g]);
    end
  endgenerate

  // pending list, bit 0 highest priority; shared vectors are or-merged sources
  always_comb begin
    pend[0]  = st_reg.req_first[0] & st_reg.en_first[0];
    pend[1]  = st_reg.req_first[1] & st_reg.en_first[1];
    pend[2]  = st_reg.req_first[2] & st_reg.en_first[2];
    pend[3]  = st_reg.req_first[3] & st_reg.en_first[3];
    pend[4]  = st_reg.req_first[4] & st_reg.en_first[4];
    pend[5]  = (|st_reg.wkp_req) & st_reg.en_first[5];
    pend[6]  = st_reg.req_first[6] & st_reg.en_first[6];
    pend[7]  = st_reg.req_first[7] & st_reg.en_first[7];
    pend[8]  = st_reg.req_second[0] & st_reg.en_second[0];
    pend[9]  = st_reg.req_second[1] & st_reg.en_second[1];
    pend[10] = st_reg.req_second[2] & st_reg.en_second[2];
    pend[11] = st_reg.req_second[3] & st_reg.en_second[3];
    pend[12] = st_reg.req_second[4] & st_reg.en_second[4];
    pend[13] = st_reg.req_second[5] & st_reg.en_second[5];
    pend[14] = st_reg.req_second[6] & st_reg.en_second[6];
    pend[15] = st_reg.req_second[7] & st_reg.en_second[7];
    pend[19:16] = 4'h0;
  end

  // vector table lookup; reserved vectors 1..3 never produced
  function automatic logic [4:0] riec_vec(input logic [3:0] slot);
    logic [4:0] v;
    v = `RIEC_VEC_RESET;
    case (slot)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: v = 5'(`RIEC_VEC_IRQ0 + 5'(slot));
      4'h5:   v = `RIEC_VEC_WKP;
      4'h6:   v = `RIEC_VEC_SER1;
      4'h7:   v = `RIEC_VEC_TMR_A;
      4'h8:   v = `RIEC_VEC_TMR_B;
      4'h9:   v = `RIEC_VEC_TMR_C;
      4'ha:   v = `RIEC_VEC_TMR_FL;
      4'hb:   v = `RIEC_VEC_TMR_FH;
      4'hc:   v = `RIEC_VEC_TMR_G;
      4'hd:   v = `RIEC_VEC_SER2;
      4'he:   v = `RIEC_VEC_SER3;
      default: v = `RIEC_VEC_ADC;
    endcase
    return v;
  endfunction

  logic [3:0] win_slot;  // highest-priority pending slot
  logic       any_pend;  // something pending
  logic       dir_pend;  // lowest: direct transfer

  // fixed-priority pick, lowest index wins
  always_comb begin
    win_slot = 4'h0;
    any_pend = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (pend[i]) begin
        win_slot = 4'(i);
        any_pend = 1'b1;
      end
    end
    dir_pend = 1'b0;
  end

  // next state: reset sequence, flags, registers
  always_comb begin
    st_next        = st_reg;
    st_next.prdata = 32'h0000_0000;
    st_next.irq_prev  = irq_pins;
    st_next.boot_prev = boot_select_pin;

    // reset sequencer
    case (st_reg.seq)
      RIEC_HOLD: begin
        st_next.gmask = 1'b1;
        if (boot_select_pin) begin
          st_next.seq = RIEC_VECT;
        end else begin
          st_next.seq = RIEC_WAIT;
        end
      end
      RIEC_WAIT: begin
        // count only after a low-to-high on the boot pin
        if (!st_reg.boot_rose) begin
          st_next.boot_rose = boot_select_pin & ~st_reg.boot_prev;
          st_next.wait_cnt  = 14'h0000;
        end else if (st_reg.wait_cnt == 14'(BOOT_WAIT_CYC - 1)) begin
          st_next.seq = RIEC_VECT;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt + 14'h0001;
        end
      end
      RIEC_VECT: begin
        // present reset vector; cpu fetches and starts the first instruction
        if (cpu_ack) begin
          st_next.seq         = RIEC_RUN;
          st_next.first_instr = 1'b1;
        end
      end
      default: begin
        if (st_reg.first_instr && instr_boundary) begin
          st_next.first_instr = 1'b0;
        end
        if (rte_set_mask) begin
          st_next.gmask = 1'b1;
        end else if (rte_clear_mask) begin
          st_next.gmask = 1'b0;
        end
        if (cpu_req.req && cpu_ack) begin
          st_next.gmask = 1'b1;  // acceptance masks further nesting
        end
      end
    endcase

    // register writes; flags: write 0 clears, 1 keeps
    if (wr_stb) begin
      if (idx == 14'(`RIEC_IDX_EDGE_SEL)) begin
        st_next.edge_sel = wr_byte[4:0];
      end else if (idx == 14'(`RIEC_IDX_EN_FIRST)) begin
        st_next.en_first = wr_byte;
      end else if (idx == 14'(`RIEC_IDX_EN_SECOND)) begin
        st_next.en_second = wr_byte;
      end else if (idx == 14'(`RIEC_IDX_REQ_FIRST)) begin
        st_next.req_first = st_reg.req_first & wr_byte;
      end else if (idx == 14'(`RIEC_IDX_REQ_SECOND)) begin
        st_next.req_second = st_reg.req_second & wr_byte;
      end else if (idx == 14'(`RIEC_IDX_WKP_REQ)) begin
        st_next.wkp_req = st_reg.wkp_req & wr_byte;
      end
    end

    // hardware sets after the clear so a same-cycle event survives; flags set even if masked
    st_next.req_first[4:0] = st_next.req_first[4:0] | irq_edge;
    st_next.req_first[6]   = st_next.req_first[6] | periph_evt.ser1_done;
    st_next.req_first[7]   = st_next.req_first[7] | periph_evt.tmr_a_ovf;
    st_next.wkp_req        = st_next.wkp_req | wakeup_pins;
    st_next.req_second[0]  = st_next.req_second[0] | periph_evt.tmr_b_ovf;
    st_next.req_second[1]  = st_next.req_second[1] | periph_evt.tmr_c_ovf | periph_evt.tmr_c_unf;
    st_next.req_second[2]  = st_next.req_second[2] | (|periph_evt.tmr_fl);
    st_next.req_second[3]  = st_next.req_second[3] | (|periph_evt.tmr_fh);
    st_next.req_second[4]  = st_next.req_second[4] | (|periph_evt.tmr_g);
    st_next.req_second[5]  = st_next.req_second[5] | (|periph_evt.ser2);
    st_next.req_second[6]  = st_next.req_second[6] | (|periph_evt.ser3);
    st_next.req_second[7]  = st_next.req_second[7] | periph_evt.adc_done;

    // read data, registered at the setup edge so it stands while pready is high
    if (rd_stb) begin
      if (idx == 14'(`RIEC_IDX_EDGE_SEL)) begin
        st_next.prdata = {24'h000000, `RIEC_EDGE_RSVD | {3'b000, st_reg.edge_sel}};
      end else if (idx == 14'(`RIEC_IDX_EN_FIRST)) begin
        st_next.prdata = {24'h000000, st_reg.en_first};
      end else if (idx == 14'(`RIEC_IDX_EN_SECOND)) begin
        st_next.prdata = {24'h000000, st_reg.en_second};
      end else if (idx == 14'(`RIEC_IDX_REQ_FIRST)) begin
        st_next.prdata = {24'h000000, st_reg.req_first};
      end else if (idx == 14'(`RIEC_IDX_REQ_SECOND)) begin
        st_next.prdata = {24'h000000, st_reg.req_second};
      end else if (idx == 14'(`RIEC_IDX_WKP_REQ)) begin
        st_next.prdata = {24'h000000, st_reg.wkp_req};
      end else if (idx == 14'(`RIEC_IDX_CTRL)) begin
        st_next.prdata = {28'h0000000, st_reg.first_instr, st_reg.gmask, st_reg.seq};
      end
    end
  end

  // flags may move between setup and access; the setup snapshot is what software sees

  // cpu request: reset vector first, else masked priority winner at a boundary
  always_comb begin
    cpu_in_reset = (st_reg.seq != RIEC_RUN) & (st_reg.seq != RIEC_VECT);
    cpu_gmask    = st_reg.gmask;
    cpu_req      = '0;
    if (st_reg.seq == RIEC_VECT) begin
      cpu_req.req      = 1'b1;
      cpu_req.vec_num  = `RIEC_VEC_RESET;
      cpu_req.vec_addr = `RIEC_RESET_VEC_ADDR;
    end else if (st_reg.seq == RIEC_RUN && any_pend && !st_reg.gmask && !st_reg.first_instr
                 && instr_boundary && !dir_pend) begin
      cpu_req.req      = 1'b1;
      cpu_req.vec_num  = riec_vec(win_slot);
      cpu_req.vec_addr = {10'h000, riec_vec(win_slot), 1'b0};
    end
  end

  // single state register; pin low forces everything to reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg            <= '0;
      st_reg.seq        <= RIEC_HOLD;
      st_reg.gmask      <= 1'b1;
      st_reg.edge_sel   <= 5'h00;
      st_reg.en_first   <= `RIEC_RST_EN_FIRST;
      st_reg.en_second  <= `RIEC_RST_EN_SECOND;
      st_reg.req_first  <= `RIEC_RST_REQ_FIRST;
      st_reg.req_second <= `RIEC_RST_REQ_SECOND;
      st_reg.wkp_req    <= `RIEC_RST_WKP_REQ;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- testbench/riec_ctrl_assertions.sv
`timescale 1ns/1ps
`include "riec_map.svh"
module riec_ctrl_checker
  import riec_pkg::*;
#(
  parameter int BOOT_WAIT_CYC = 8  // boot delay of the watched instance
) (
  input wire logic          pclk,            // system clock
  input wire logic          presetn,         // async reset, active low
  input wire logic          boot_select_pin, // mode strap
  input wire logic          instr_boundary,  // cpu at boundary
  input wire logic          cpu_ack,         // cpu took vector
  input wire logic          cpu_in_reset,    // core held
  input wire logic          cpu_gmask,       // global mask
  input wire riec_cpu_req_t cpu_req          // vector request
);
  logic        boot_q;     // strap one cycle ago
  logic        rose_seen;  // strap rose while held
  logic [15:0] wait_cnt;   // cycles since that rise
  logic        first_pend; // reset vector taken, no boundary yet

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // helper state; strap starts high so a high strap at release is no rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q     <= 1'b1;
      rose_seen  <= 1'b0;
      wait_cnt   <= 16'h0000;
      first_pend <= 1'b0;
    end else begin
      boot_q <= boot_select_pin;
      if (cpu_in_reset && boot_select_pin && !boot_q) rose_seen <= 1'b1;
      if (rose_seen && cpu_in_reset) wait_cnt <= wait_cnt + 16'h0001;
      if (cpu_ack && cpu_req.req && cpu_req.vec_num == `RIEC_VEC_RESET) first_pend <= 1'b1;
      else if (instr_boundary) first_pend <= 1'b0;
    end
  end

  sequence reset_vec_s;
    cpu_req.req && cpu_req.vec_num == `RIEC_VEC_RESET && cpu_req.vec_addr == `RIEC_RESET_VEC_ADDR;
  endsequence
  sequence reset_ack_s;
    cpu_ack and reset_vec_s;
  endsequence

  AST_RESET_VECTOR: assert property ($fell(cpu_in_reset) |-> reset_vec_s)
    else $error("reset release without reset vector");
  AST_BOOT_HIGH: assert property ($rose(presetn) && boot_select_pin |-> ##[0:2] reset_vec_s)
    else $error("no reset vector after release with strap high");
  AST_BOOT_HOLD: assert property (cpu_in_reset && !boot_select_pin |=> cpu_in_reset)
    else $error("reset left while strap low");
  AST_BOOT_WAIT: assert property ($fell(cpu_in_reset) && rose_seen |->
      wait_cnt >= BOOT_WAIT_CYC - 1 && wait_cnt <= BOOT_WAIT_CYC + 3)
    else $error("strap delay count wrong");
  AST_RESET_MASK: assert property (reset_ack_s |=> cpu_gmask && !cpu_req.req)
    else $error("mask clear after reset vector");
  AST_FIRST_INSTR: assert property (first_pend && instr_boundary |-> !cpu_req.req)
    else $error("interrupt before first instruction");
  AST_AT_BOUNDARY: assert property (cpu_req.req && cpu_req.vec_num != `RIEC_VEC_RESET |-> instr_boundary)
    else $error("interrupt request off boundary");
  AST_MASK_HOLDS: assert property (cpu_gmask |-> !(cpu_req.req && cpu_req.vec_num != `RIEC_VEC_RESET))
    else $error("interrupt while masked");
  AST_VEC_ADDR: assert property (cpu_req.req |-> cpu_req.vec_addr == {10'h000, cpu_req.vec_num, 1'b0})
    else $error("vector address not twice number");
  AST_NO_RSVD: assert property (cpu_req.req |-> cpu_req.vec_num inside {5'd0, [5'd4:5'd19]})
    else $error("reserved vector used");
endmodule

bind riec_ctrl riec_ctrl_checker #(.BOOT_WAIT_CYC(BOOT_WAIT_CYC)) riec_ctrl_checker_inst (
  .pclk(pclk), .presetn(presetn), .boot_select_pin(boot_select_pin), .instr_boundary(instr_boundary),
  .cpu_ack(cpu_ack), .cpu_in_reset(cpu_in_reset), .cpu_gmask(cpu_gmask), .cpu_req(cpu_req));

//--- testbench/riec_cpu_model.sv
`timescale 1ns/1ps
module riec_cpu_model
  import riec_pkg::*;
(
  input  wire logic          pclk,           // system clock
  input  wire logic          presetn,        // async reset, active low
  input  wire logic          slow,           // stretch each acknowledge
  input  wire riec_cpu_req_t cpu_req,        // vector request
  output logic               instr_boundary, // between instructions
  output logic               cpu_ack         // vector taken
);
  logic [1:0] dly;  // cycles waited before ack
  logic [1:0] step; // instruction length counter

  // boundary held high while a request waits, so the request stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_boundary <= 1'b0;
      cpu_ack        <= 1'b0;
      dly            <= 2'd0;
      step           <= 2'd0;
    end else if (cpu_ack) begin
      cpu_ack        <= 1'b0;
      instr_boundary <= 1'b0; // exception fetch underway
    end else if (cpu_req.req && (instr_boundary || cpu_req.vec_num == 5'd0)) begin
      if (dly == (slow ? 2'd3 : 2'd0)) begin
        cpu_ack <= 1'b1;
        dly     <= 2'd0;
      end else begin
        dly <= dly + 2'd1;
      end
    end else begin
      step           <= step + 2'd1;
      instr_boundary <= (step == 2'd3);
    end
  end
endmodule

//--- testbench/riec_ctrl_test.sv
`timescale 1ns/1ps
`include "riec_map.svh"
module riec_ctrl_test;
  import riec_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          boot_select_pin, instr_boundary, cpu_ack, rte_clear_mask, rte_set_mask, slow;
  logic          cpu_in_reset, cpu_gmask, err;
  logic [4:0]    irq_pins, sel, v;
  logic [7:0]    wakeup_pins, wkp_pat;
  logic [19:0]   pend;      // pending sources by vector number
  riec_evt_t     periph_evt, ev;
  riec_cpu_req_t cpu_req;
  logic [4:0]    acks[$];   // vectors taken, in order
  int            error_cnt, num_checks, n;
  logic [15:0]   ridx [6] = '{`RIEC_IDX_EDGE_SEL, `RIEC_IDX_EN_FIRST, `RIEC_IDX_EN_SECOND,
                              `RIEC_IDX_REQ_FIRST, `RIEC_IDX_REQ_SECOND, `RIEC_IDX_WKP_REQ};
  logic [7:0]    rval [6] = '{8'he0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};

  riec_ctrl #(.BOOT_WAIT_CYC(8)) riec_ctrl_inst (.*);
  riec_cpu_model riec_cpu_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .cpu_req(cpu_req),
    .instr_boundary(instr_boundary), .cpu_ack(cpu_ack));

  always #10 pclk = ~pclk;
  // record every vector the cpu takes
  always @(posedge pclk) if (cpu_ack && cpu_req.req) acks.push_back(cpu_req.vec_num);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic give_up();
    error_cnt++;
    $display("mismatch at %0t: wait timed out", $time);
    report_and_stop();
  endtask
  // one apb transfer, entered right after a rising edge; answer taken at the pready edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdat, output logic serr);
    int k;
    paddr  <= {idx[13:0], 2'b00};
    pwrite <= wr;
    pwdata <= {24'h0, wd};
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) give_up();
    serr = pslverr;
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_ack();
    for (n = 0; n < 60 && acks.size() == 0; n++) @(posedge pclk);
    if (acks.size() == 0) give_up();
  endtask
  task automatic read_flags();
    apb(1'b0, `RIEC_IDX_REQ_FIRST, 8'h00, rd, err);
    check(rd & 32'hdf, {24'h0, pend[11:10], 1'b0, pend[8:4]});
    apb(1'b0, `RIEC_IDX_REQ_SECOND, 8'h00, rd, err);
    check(rd, {24'h0, pend[19:12]});
    apb(1'b0, `RIEC_IDX_WKP_REQ, 8'h00, rd, err);
    check(rd, {24'h0, pend[9] ? wkp_pat : 8'h00});
  endtask
  function automatic logic [4:0] first_vec(input logic [19:0] p);
    for (int i = 4; i < 20; i++) if (p[i]) return 5'(i);
    return 5'd0;
  endfunction

  initial begin
    void'($urandom(32'hc37e73e7));
    {pclk, presetn, psel, penable, pwrite, boot_select_pin, rte_clear_mask, rte_set_mask, slow} = '0;
    {paddr, pwdata, irq_pins, wakeup_pins, periph_evt} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    check(cpu_in_reset, 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ridx[i], 8'h00, rd, err);
      check(rd, {24'h0, rval[i]});
    end
    apb(1'b0, 16'hfff5, 8'h00, rd, err);
    check(err, 32'h1);
    check(rd, 32'h0);
    boot_select_pin <= 1'b1;
    wait_ack();
    check(acks[0], 32'h0);
    check(cpu_gmask, 32'h1);
    apb(1'b1, `RIEC_IDX_EN_FIRST, 8'hff, rd, err);
    apb(1'b1, `RIEC_IDX_EN_SECOND, 8'hff, rd, err);
    for (int r = 0; r < 6; r++) begin
      slow <= r[0];
      rte_set_mask   <= 1'b1;
      rte_clear_mask <= 1'b1;
      @(posedge pclk);
      {rte_set_mask, rte_clear_mask} <= 2'b00;
      @(posedge pclk);
      check(cpu_gmask, 32'h1);
      pend = {16'($urandom), 4'h0};
      sel = 5'($urandom);
      wkp_pat = 8'h01 << $urandom_range(0, 7);
      apb(1'b1, `RIEC_IDX_EDGE_SEL, {3'b000, sel}, rd, err);
      apb(1'b0, `RIEC_IDX_EDGE_SEL, 8'h00, rd, err);
      check(rd, {24'h0, 3'b111, sel});
      irq_pins <= ~sel;
      ev = '0;
      {ev.ser1_done, ev.tmr_a_ovf, ev.tmr_b_ovf} = {pend[10], pend[11], pend[12]};
      {ev.tmr_c_ovf, ev.tmr_c_unf} = {pend[13] & r[0], pend[13] & ~r[0]};
      ev.tmr_fl = pend[14] ? 2'b01 << r[0] : 2'b00;
      ev.tmr_fh = pend[15] ? 2'b10 >> r[0] : 2'b00;
      ev.tmr_g = pend[16] ? 2'b01 << r[0] : 2'b00;
      ev.ser2 = pend[17] ? 2'b01 << r[0] : 2'b00;
      ev.ser3 = pend[18] ? 6'h01 << (r % 6) : 6'h00;
      {ev.adc_done, ev.direct_xfer} = {pend[19], r[0]};
      @(posedge pclk);
      irq_pins    <= ~sel ^ pend[8:4];
      wakeup_pins <= pend[9] ? wkp_pat : 8'h00;
      periph_evt  <= ev;
      @(posedge pclk);
      wakeup_pins <= 8'h00;
      periph_evt  <= '0;
      repeat (2) @(posedge pclk);
      check(cpu_req.req, 32'h0);
      read_flags();
      // unmask, take one vector, clear its flag, repeat
      while (pend != 20'h0) begin
        v = first_vec(pend);
        acks.delete();
        rte_clear_mask <= 1'b1;
        @(posedge pclk);
        rte_clear_mask <= 1'b0;
        wait_ack();
        check(acks[0], v);
        pend[v] = 1'b0;
        if (v == `RIEC_VEC_WKP) apb(1'b1, `RIEC_IDX_WKP_REQ, 8'h00, rd, err);
        else if (v < 5'd12) apb(1'b1, `RIEC_IDX_REQ_FIRST, ~(8'h01 << (v - 5'd4)), rd, err);
        else apb(1'b1, `RIEC_IDX_REQ_SECOND, ~(8'h01 << (v - 5'd12)), rd, err);
        read_flags();
      end
    end
    presetn <= 1'b0;
    #1 check({cpu_in_reset, cpu_gmask, cpu_req.req}, 32'h6);
    repeat (12) @(posedge pclk);
    acks.delete();
    presetn <= 1'b1;
    wait_ack();
    check(acks[0], 32'h0);
    apb(1'b0, `RIEC_IDX_EN_FIRST, 8'h00, rd, err);
    check(rd, 32'h0);
    report_and_stop();
  end
endmodule
